// *** phy_ctrl_pkg.sv ***
// Constants for the basic mode control register and its datapath.
package phy_ctrl_pkg;
  // Register width and field positions
  localparam int REG_W = 16;
  localparam int BIT_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_RATE = 13;
  localparam int BIT_AN_EN = 12;
  localparam int BIT_LOW_POWER = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;
  // Reserved field mask, bits 6:0
  localparam logic [15:0] RSVD_MASK = 16'h007f;
  // Field defaults
  localparam logic DEF_LOOPBACK = 1'b0;
  localparam logic DEF_RATE = 1'b1;
  localparam logic DEF_AN_EN = 1'b1;
  localparam logic DEF_LOW_POWER = 1'b0;
  localparam logic DEF_DUPLEX = 1'b0;
  localparam logic DEF_COL_TEST = 1'b0;
  localparam logic [4:0] ISOLATE_ADDR = 5'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
  localparam int BIT_TIME_NS = 10;
  localparam int LOOP_MAX_BITS = 512;
  localparam int LOOP_MAX_CYCLES =
    (LOOP_MAX_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_OFF_CYCLES =
    (COL_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST =
    RST_CNT_W'(SOFT_RESET_CYCLES - 1);
  // Soft reset sequencer states
  typedef enum logic {ST_RUN, ST_SOFT_RESET} sreset_state_t;
endpackage

// *** phy_basic_control_register.sv ***
// Basic mode control register with strap override and MAC loopback path.
module phy_basic_control_register (
  input wire logic clk,
  input wire logic srst,
  // Management access port
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [phy_ctrl_pkg::REG_W-1:0] mgmt_wdata,
  output logic [phy_ctrl_pkg::REG_W-1:0] mgmt_rdata,
  output logic mgmt_busy,
  // Straps
  input wire logic strap_mode_select_pin,
  input wire logic rate_strap_pin,
  input wire logic autoneg_strap_pin,
  input wire logic duplex_strap_pin,
  input wire logic [4:0] phy_addr_strap,
  // Negotiation sublayer
  input wire logic an_started,
  input wire logic an_result_100,
  input wire logic an_result_full,
  input wire logic an_complete_evt,
  input wire logic status_rd,
  output logic an_done_flag,
  output logic autoneg_enable,
  output logic autoneg_restart,
  output logic speed_100,
  output logic full_duplex,
  output logic sm_idle_reset,
  output logic low_power,
  output logic line_tx_enable,
  output logic line_rx_enable,
  output logic line_transmit_tristate,
  output logic col_detect_enable,
  // MAC side
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic tx_er,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_er,
  input wire logic line_crs,
  input wire logic line_col,
  output logic mac_oe,
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic rx_er,
  output logic crs,
  output logic col
);
  import phy_ctrl_pkg::*;
  // Stored control fields
  logic reset_bit_ff;
  logic loopback_ff;
  logic rate_ff;
  logic an_en_ff;
  logic low_power_ff;
  logic isolate_ff;
  logic an_restart_ff;
  logic duplex_ff;
  logic col_test_ff;
  // Captured straps
  logic hw_mode_ff;
  logic rate_pin_ff;
  logic an_pin_ff;
  logic dpx_pin_ff;
  logic iso_def_ff;
  // Soft reset sequencer
  sreset_state_t state_ff;
  logic [RST_CNT_W-1:0] rst_cnt_ff;
  // Accepted write, refused while soft reset runs
  logic wr_ok;
  // Low power entry through a write
  logic lp_entry;
  // Effective mode after strap override
  logic eff_an;
  logic eff_100;
  logic eff_full;
  // MAC inputs gated off in low power, isolate and soft reset
  logic tx_en_g;
  logic [3:0] txd_g;
  logic tx_er_g;
  logic active;
  assign wr_ok = mgmt_wr && (state_ff == ST_RUN);
  assign lp_entry = wr_ok && mgmt_wdata[BIT_LOW_POWER] && !low_power_ff;
  assign active = !low_power_ff && !isolate_ff && (state_ff == ST_RUN);
  // Strap capture; a soft reset keeps the captured straps
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_mode_ff <= !strap_mode_select_pin;
      rate_pin_ff <= rate_strap_pin;
      an_pin_ff <= autoneg_strap_pin;
      dpx_pin_ff <= duplex_strap_pin;
      iso_def_ff <= (phy_addr_strap == ISOLATE_ADDR);
    end
  end
  // Soft reset sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_RUN;
      rst_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (wr_ok && mgmt_wdata[BIT_RESET]) begin
            state_ff <= ST_SOFT_RESET;
            rst_cnt_ff <= '0;
          end
        end
        ST_SOFT_RESET: begin
          // Fixed length so the manager sees a bounded busy time
          if (rst_cnt_ff == RST_CNT_LAST) begin
            state_ff <= ST_RUN;
          end else begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end
  // Reset bit and busy flag
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_bit_ff <= 1'b0;
      mgmt_busy <= 1'b0;
      sm_idle_reset <= 1'b0;
    end else begin
      if (wr_ok && mgmt_wdata[BIT_RESET]) begin
        reset_bit_ff <= 1'b1;
        mgmt_busy <= 1'b1;
        sm_idle_reset <= 1'b1;
      end else if (state_ff == ST_SOFT_RESET
                   && rst_cnt_ff == RST_CNT_LAST) begin
        reset_bit_ff <= 1'b0;
        mgmt_busy <= 1'b0;
        sm_idle_reset <= 1'b0;
      end
    end
  end
  // Plain control fields
  always_ff @(posedge clk) begin
    if (srst || state_ff == ST_SOFT_RESET) begin
      loopback_ff <= DEF_LOOPBACK;
      rate_ff <= DEF_RATE;
      an_en_ff <= DEF_AN_EN;
      low_power_ff <= DEF_LOW_POWER;
      duplex_ff <= DEF_DUPLEX;
      col_test_ff <= DEF_COL_TEST;
      isolate_ff <= srst ? (phy_addr_strap == ISOLATE_ADDR) : iso_def_ff;
    end else if (wr_ok && !mgmt_wdata[BIT_RESET]) begin
      loopback_ff <= mgmt_wdata[BIT_LOOPBACK];
      rate_ff <= mgmt_wdata[BIT_RATE];
      an_en_ff <= mgmt_wdata[BIT_AN_EN];
      low_power_ff <= mgmt_wdata[BIT_LOW_POWER];
      isolate_ff <= mgmt_wdata[BIT_ISOLATE];
      duplex_ff <= mgmt_wdata[BIT_DUPLEX];
      col_test_ff <= mgmt_wdata[BIT_COL_TEST];
    end
  end
  // Restart bit, self clearing
  always_ff @(posedge clk) begin
    if (srst || state_ff == ST_SOFT_RESET) begin
      an_restart_ff <= 1'b0;
    end else if (wr_ok && mgmt_wdata[BIT_AN_RESTART] && !hw_mode_ff
                 && mgmt_wdata[BIT_AN_EN]) begin
      an_restart_ff <= 1'b1;
    end else if (an_started || !an_en_ff) begin
      an_restart_ff <= 1'b0;
    end
  end
  // Effective mode selection
  always_comb begin
    // pin chooses negotiation in hardware mode
    eff_an = hw_mode_ff ? an_pin_ff : an_en_ff;
    if (hw_mode_ff) begin
      eff_100 = rate_pin_ff;
      eff_full = dpx_pin_ff;
    end else if (an_en_ff) begin
      eff_100 = an_result_100;
      eff_full = an_result_full;
    end else begin
      eff_100 = rate_ff;
      eff_full = duplex_ff;
    end
  end
  // Mode outputs toward the rest of the device
  always_ff @(posedge clk) begin
    if (srst) begin
      autoneg_enable <= 1'b0;
      autoneg_restart <= 1'b0;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      low_power <= 1'b0;
      line_tx_enable <= 1'b0;
      line_rx_enable <= 1'b0;
      line_transmit_tristate <= 1'b0;
      col_detect_enable <= 1'b0;
      mac_oe <= 1'b0;
    end else begin
      autoneg_enable <= eff_an && !low_power_ff;
      autoneg_restart <= an_restart_ff;
      speed_100 <= eff_100;
      // Duplex choice has no effect in loopback, half is forced
      full_duplex <= eff_full && !loopback_ff;
      low_power <= low_power_ff;
      line_transmit_tristate <= low_power_ff;
      line_tx_enable <= !loopback_ff && !low_power_ff;
      line_rx_enable <= !loopback_ff && !low_power_ff;
      col_detect_enable <= (!loopback_ff || col_test_ff) && !low_power_ff;
      mac_oe <= !isolate_ff;
    end
  end
  assign tx_en_g = tx_en && active;
  assign txd_g = active ? txd : 4'h0;
  assign tx_er_g = tx_er && active;
  // Receive path toward the MAC
  always_ff @(posedge clk) begin
    if (srst || !active) begin
      rx_dv <= 1'b0;
      rxd <= 4'h0;
      rx_er <= 1'b0;
      crs <= 1'b0;
    end else if (loopback_ff) begin
      rx_dv <= tx_en_g;
      rxd <= txd_g;
      rx_er <= tx_er_g;
      crs <= tx_en_g;
    end else begin
      rx_dv <= line_rx_dv;
      rxd <= line_rxd;
      rx_er <= line_rx_er;
      crs <= line_crs;
    end
  end
  // Collision output
  always_ff @(posedge clk) begin
    if (srst || !active) begin
      col <= 1'b0;
    end else if (col_test_ff) begin
      col <= tx_en_g;
    end else begin
      col <= line_col && !loopback_ff;
    end
  end
  // Latching high negotiation done flag
  always_ff @(posedge clk) begin
    if (srst || state_ff == ST_SOFT_RESET || lp_entry) begin
      an_done_flag <= 1'b0;
    end else if (status_rd) begin
      an_done_flag <= an_complete_evt;
    end else if (an_complete_evt) begin
      an_done_flag <= 1'b1;
    end
  end
  // Read data; reads during soft reset still show the reset bit
  always_ff @(posedge clk) begin
    if (srst) begin
      mgmt_rdata <= '0;
    end else if (mgmt_rd) begin
      mgmt_rdata <= '0;
      mgmt_rdata[BIT_RESET] <= reset_bit_ff;
      mgmt_rdata[BIT_LOOPBACK] <= loopback_ff;
      mgmt_rdata[BIT_RATE] <= rate_ff;
      mgmt_rdata[BIT_AN_EN] <= an_en_ff;
      mgmt_rdata[BIT_LOW_POWER] <= low_power_ff;
      mgmt_rdata[BIT_ISOLATE] <= isolate_ff;
      mgmt_rdata[BIT_AN_RESTART] <= an_restart_ff;
      mgmt_rdata[BIT_DUPLEX] <= duplex_ff;
      mgmt_rdata[BIT_COL_TEST] <= col_test_ff;
    end
  end
  // Sequences for the soft reset walk
  sequence s_reset_req;
    wr_ok && mgmt_wdata[BIT_RESET];
  endsequence
  sequence s_reset_busy;
    reset_bit_ff && mgmt_busy;
  endsequence
  a_reset_busy_hold: assert property (
    @(posedge clk) disable iff (srst)
    s_reset_req |=> s_reset_busy [*8])
    else $error("reset bit dropped early");
  a_reset_defaults: assert property (
    @(posedge clk) disable iff (srst)
    s_reset_req ##1 s_reset_busy |=> !loopback_ff && an_en_ff && rate_ff)
    else $error("soft reset left non default fields");
  a_reset_ends: assert property (
    @(posedge clk) disable iff (srst)
    $rose(reset_bit_ff) |-> ##[1:60] !reset_bit_ff)
    else $error("soft reset never finished");
  a_loop_line_off: assert property (
    @(posedge clk) disable iff (srst)
    loopback_ff |=> !line_tx_enable && !line_rx_enable
      && (col_detect_enable == ($past(col_test_ff) && !$past(low_power_ff))))
    else $error("line side active in loopback");
  a_loop_return: assert property (
    @(posedge clk) disable iff (srst)
    loopback_ff && active && tx_en && $stable(loopback_ff)
      |=> rx_dv || !active)
    else $error("loopback receive valid late");
  a_hw_rate_pin: assert property (
    @(posedge clk) disable iff (srst)
    hw_mode_ff |=> speed_100 == $past(rate_pin_ff))
    else $error("hardware rate not from pin");
  a_sw_rate_bit: assert property (
    @(posedge clk) disable iff (srst)
    !hw_mode_ff && !an_en_ff |=> speed_100 == $past(rate_ff))
    else $error("software rate not from bit");
  a_hw_an_pin: assert property (
    @(posedge clk) disable iff (srst)
    hw_mode_ff && !low_power_ff |=> autoneg_enable == $past(an_pin_ff))
    else $error("negotiation enable not from pin");
  a_lp_outputs: assert property (
    @(posedge clk) disable iff (srst)
    low_power_ff |=> !rx_dv && !col && !crs && line_transmit_tristate)
    else $error("MAC outputs active in low power");
  a_lp_keeps_regs: assert property (
    @(posedge clk) disable iff (srst)
    lp_entry |=> !an_done_flag && low_power_ff
      && rate_ff == $past(mgmt_wdata[BIT_RATE]))
    else $error("low power entry lost register state");
  a_isolate_float: assert property (
    @(posedge clk) disable iff (srst)
    isolate_ff ##1 isolate_ff |-> !mac_oe && !rx_dv)
    else $error("MAC outputs driven while isolated");
  a_restart_gate: assert property (
    @(posedge clk) disable iff (srst)
    !an_restart_ff && wr_ok && !mgmt_wdata[BIT_AN_EN] |=> !an_restart_ff)
    else $error("restart set without negotiation");
  a_col_test: assert property (
    @(posedge clk) disable iff (srst)
    col_test_ff && active && $stable(col_test_ff) |=> col == $past(tx_en))
    else $error("collision test COL not following TXEN");
  a_rsvd_zero: assert property (
    @(posedge clk) disable iff (srst)
    (mgmt_rdata & RSVD_MASK) == 16'h0000)
    else $error("reserved bits read non zero");
  a_lh_hold: assert property (
    @(posedge clk) disable iff (srst)
    an_done_flag && !status_rd && !lp_entry && state_ff == ST_RUN
      |=> an_done_flag)
    else $error("latching flag lost before read");
endmodule

// *** phy_far_side_model.sv ***
// Negotiator and line-side model facing the control block.
module phy_far_side_model #(
  parameter int START_DLY = 3,
  parameter logic RES_100 = 1'b0,
  parameter logic RES_FULL = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic autoneg_restart,
  output logic an_started,
  output logic an_result_100,
  output logic an_result_full,
  output logic line_rx_dv,
  output logic [3:0] line_rxd,
  output logic line_rx_er,
  output logic line_crs,
  output logic line_col
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff; // Wait since restart seen
  logic [3:0] pat_ff; // Line pattern, new every cycle
  // Negotiated result held steady
  assign an_result_100 = RES_100;
  assign an_result_full = RES_FULL;
  // Line kept busy so any leak into loopback shows up
  assign line_rx_dv = 1'b1;
  assign line_crs = 1'b1;
  assign line_rxd = pat_ff;
  assign line_rx_er = pat_ff[0];
  assign line_col = pat_ff[1];
  // Negotiation starts a few cycles after a restart request
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 8'h00;
      an_started <= 1'b0;
    end else begin
      an_started <= 1'b0;
      if (autoneg_restart && !an_started) begin
        cnt_ff <= cnt_ff + 8'h01;
        if (cnt_ff == 8'(START_DLY)) begin
          an_started <= 1'b1;
          cnt_ff <= 8'h00;
        end
      end else if (!autoneg_restart) begin
        // Idle between requests, no leftover count
        cnt_ff <= 8'h00;
      end
    end
  end
  // Free running pattern, never the last value twice
  always_ff @(posedge clk) begin
    pat_ff <= srst ? 4'h0 : pat_ff + 4'h1;
  end
endmodule

// *** test_phy_basic_control_register.sv ***
// Self-checking bench for the basic mode control register.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end
module test_phy_basic_control_register;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_ctrl_pkg::*;
  logic clk, srst, mgmt_wr, mgmt_rd, mgmt_busy;
  logic [15:0] mgmt_wdata, mgmt_rdata, rd_data;
  logic strap_mode_select_pin, rate_strap_pin;
  logic autoneg_strap_pin, duplex_strap_pin;
  logic [4:0] phy_addr_strap;
  logic an_started, an_result_100, an_result_full;
  logic an_complete_evt, status_rd, an_done_flag;
  logic autoneg_enable, autoneg_restart, speed_100, full_duplex;
  logic sm_idle_reset, low_power, line_tx_enable, line_rx_enable;
  logic line_transmit_tristate, col_detect_enable;
  logic tx_en, tx_er, line_rx_dv, line_rx_er, line_crs, line_col;
  logic [3:0] txd, line_rxd, rxd;
  logic mac_oe, rx_dv, rx_er, crs, col;
  int n_errors, checks_done, i;
  // Design under test
  phy_basic_control_register dut (.clk, .srst, .mgmt_wr, .mgmt_rd,
    .mgmt_wdata, .mgmt_rdata, .mgmt_busy, .strap_mode_select_pin,
    .rate_strap_pin, .autoneg_strap_pin, .duplex_strap_pin,
    .phy_addr_strap, .an_started, .an_result_100, .an_result_full,
    .an_complete_evt, .status_rd, .an_done_flag, .autoneg_enable,
    .autoneg_restart, .speed_100, .full_duplex, .sm_idle_reset,
    .low_power, .line_tx_enable, .line_rx_enable,
    .line_transmit_tristate, .col_detect_enable, .tx_en, .txd, .tx_er,
    .line_rx_dv, .line_rxd, .line_rx_er, .line_crs, .line_col, .mac_oe,
    .rx_dv, .rxd, .rx_er, .crs, .col);
  // Negotiator and line on the far side
  phy_far_side_model far (.clk, .srst, .autoneg_restart, .an_started,
    .an_result_100, .an_result_full, .line_rx_dv, .line_rxd,
    .line_rx_er, .line_crs, .line_col);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Register write, reserved bits always sent as zero
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    mgmt_wdata = d & ~RSVD_MASK;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
    @(negedge clk);
  endtask
  // Register read, data taken once the answer has landed
  task automatic rd(output logic [15:0] d);
    @(negedge clk);
    mgmt_rd = 1'b1;
    @(negedge clk);
    mgmt_rd = 1'b0;
    @(negedge clk);
    d = mgmt_rdata;
  endtask
  // Hard reset with given straps
  task automatic do_reset(input logic m, r, a, d, input logic [4:0] ad);
    srst = 1'b1;
    strap_mode_select_pin = m;
    rate_strap_pin = r;
    autoneg_strap_pin = a;
    duplex_strap_pin = d;
    phy_addr_strap = ad;
    repeat (16) @(negedge clk);
    srst = 1'b0;
  endtask
  // One pulse on the event input (sel 0) or the flag read (sel 1)
  task automatic pulse(input bit sel);
    @(negedge clk);
    if (sel)
      status_rd = 1'b1;
    else
      an_complete_evt = 1'b1;
    @(negedge clk);
    {an_complete_evt, status_rd} = 2'b00;
    @(negedge clk);
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    n_errors = 0;
    checks_done = 0;
    {mgmt_wr, mgmt_rd, an_complete_evt, status_rd, tx_en, tx_er} = '0;
    mgmt_wdata = 16'h0000;
    txd = 4'h0;
    do_reset(1'b1, 1'b0, 1'b0, 1'b0, 5'h01);
    rd(rd_data);
    `CHK(rd_data, 16'h3000)
    // Forced modes, negotiation off
    wr(16'h2100);
    `CHK({speed_100, full_duplex, autoneg_enable}, 3'b110)
    wr(16'h0000);
    `CHK({speed_100, full_duplex}, 2'b00)
    `CHK(rx_dv, 1'b1)
    // Restart ignored while negotiation is off
    wr(16'h0200);
    rd(rd_data);
    `CHK(rd_data, 16'h0000)
    // Negotiation on: result wins over rate and duplex bits
    wr(16'h3300);
    `CHK({speed_100, full_duplex}, {an_result_100, an_result_full})
    `CHK(autoneg_restart, 1'b1)
    i = 0;
    while (autoneg_restart !== 1'b0 && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (i == 50) begin
      n_errors++;
      results();
    end
    rd(rd_data);
    `CHK(rd_data, 16'h3100)
    // Loopback without collision test
    wr(16'h4000);
    `CHK({line_tx_enable, line_rx_enable, col_detect_enable}, 3'h0)
    tx_en = 1'b1;
    txd = 4'h5;
    @(negedge clk);
    `CHK({rx_dv, rxd, col}, 6'b1_0101_0)
    txd = 4'hc;
    tx_er = 1'b1;
    @(negedge clk);
    `CHK({rxd, rx_er, col}, 6'b1100_1_0)
    tx_er = 1'b0;
    // Collision test in loopback, duplex bit without effect
    wr(16'h4180);
    `CHK({col, col_detect_enable, full_duplex}, 3'b110)
    tx_en = 1'b0;
    repeat (COL_OFF_CYCLES) @(negedge clk);
    `CHK({col, rx_dv}, 2'b00)
    // Isolate floats the MAC side
    wr(16'h0400);
    tx_en = 1'b1;
    @(negedge clk);
    `CHK({mac_oe, rx_dv}, 2'b00)
    tx_en = 1'b0;
    // Latching flag: set, then reload on read
    wr(16'h0000);
    pulse(1'b0);
    `CHK(an_done_flag, 1'b1)
    pulse(1'b1);
    `CHK(an_done_flag, 1'b0)
    // Low power clears flag, keeps contents
    pulse(1'b0);
    wr(16'h0800);
    `CHK({an_done_flag, low_power, line_transmit_tristate}, 3'b011)
    `CHK({rx_dv, crs}, 2'b00)
    rd(rd_data);
    `CHK(rd_data, 16'h0800)
    // Soft reset: busy, refused write, self clear, defaults
    wr(16'h0180);
    wr(16'h8000);
    rd(rd_data);
    `CHK({rd_data[BIT_RESET], mgmt_busy, sm_idle_reset}, 3'b111)
    wr(16'h0100);
    i = 0;
    while (rd_data[BIT_RESET] !== 1'b0 && i < 40) begin
      rd(rd_data);
      i++;
    end
    if (i == 40) begin
      n_errors++;
      results();
    end
    rd(rd_data);
    `CHK(rd_data, 16'h3000)
    // Hardware mode at address zero
    do_reset(1'b0, 1'b1, 1'b0, 1'b1, 5'h00);
    rd(rd_data);
    `CHK({rd_data[BIT_ISOLATE], mac_oe}, 2'b10)
    wr(16'h1600);
    `CHK(speed_100, 1'b1)
    `CHK({autoneg_enable, autoneg_restart}, 2'b00)
    `CHK(full_duplex, 1'b1)
    results();
  end
endmodule
